/* common/ecc_cmd_params.svh */
`ifndef ECC_CMD_PARAMS_SVH
`define ECC_CMD_PARAMS_SVH

// register byte addresses
`define ECC_CMD_ADDR_COMMAND    32'h5000_6004
`define ECC_CMD_ADDR_CONTROL    32'h5000_6008
`define ECC_CMD_ADDR_STATUS     32'h5000_600C
`define ECC_CMD_ADDR_LAUNCH     32'h5000_6018

// command register fields
`define ECC_CMD_RECOMPUTE_BIT   31
`define ECC_CMD_SIGN_B_BIT      30
`define ECC_CMD_SIGN_A_BIT      29
`define ECC_CMD_RSVD_MSB        28
`define ECC_CMD_RSVD_LSB        16
`define ECC_CMD_DWORDS_MSB      15
`define ECC_CMD_DWORDS_LSB      8
`define ECC_CMD_FIELD_BIT       7
`define ECC_CMD_OPGROUP_MSB     6
`define ECC_CMD_OPGROUP_LSB     4
`define ECC_CMD_OPLOW_MSB       3
`define ECC_CMD_OPLOW_LSB       0
`define ECC_CMD_RESET           32'h0000_0000

// control, status and launch fields
`define ECC_CTL_START_BIT       0
`define ECC_STS_BUSY_BIT        16
`define ECC_LCH_REFUSED_BIT     0
`define ECC_LCH_PENDING_BIT     1

// primitive group and low codes
`define ECC_GROUP_PRIMITIVE     3'h0
`define ECC_OP_RSVD0            4'h0
`define ECC_OP_MOD_ADD          4'h1
`define ECC_OP_MOD_SUB          4'h2
`define ECC_OP_MOD_MUL          4'h3
`define ECC_OP_MOD_RED          4'h4
`define ECC_OP_MOD_DIV          4'h5
`define ECC_OP_MOD_INV_ODD      4'h6
`define ECC_OP_RSVD7            4'h7
`define ECC_OP_MUL              4'h8
`define ECC_OP_MOD_INV_EVEN     4'h9

// operand size codes
`define ECC_SIZE_KEY_128        8'h02
`define ECC_SIZE_KEY_256        8'h03
`define ECC_SIZE_CURVE_192      8'h03
`define ECC_SIZE_CURVE_256      8'h04
`define ECC_BITS_128            16'h0080
`define ECC_BITS_192            16'h00C0
`define ECC_BITS_256            16'h0100
`define ECC_DWORD_BITS          6

// timing counts of the arithmetic sequencer, in clock cycles
`define ECC_RMODN_CYCLES        16'h0040
`define ECC_CYCLES_PER_DWORD    16'h0008
`define ECC_OP_BASE_CYCLES      16'h0004

`endif

/* common/ecc_cmd_pkg.sv */
`default_nettype none
package ecc_cmd_pkg;

  typedef enum logic [3:0] {
    prim_none,
    prim_mod_add,
    prim_mod_sub,
    prim_mod_mul,
    prim_mod_red,
    prim_mod_div,
    prim_mod_inv_odd,
    prim_mul,
    prim_mod_inv_even
  } prim_op_e;

  typedef struct packed {
    logic       recompute_r_mod_n;
    logic       param_b_negative;
    logic       param_a_negative;
    logic [7:0] operand_dword_count;
    logic       field_binary;
    logic [6:0] operation_code;
  } command_s;

  typedef struct packed {
    prim_op_e   op;
    logic       field_binary;
    logic       param_a_negative;
    logic       param_b_negative;
    logic [7:0] operand_dword_count;
    logic [15:0] key_width_bits;
    logic [15:0] curve_width_bits;
  } exec_s;

  typedef enum logic [1:0] {
    phase_idle,
    phase_rmodn,
    phase_oper
  } seq_phase_e;

endpackage : ecc_cmd_pkg
`default_nettype wire

/* logic/ecc_op_seq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecc_cmd_params.svh"

module ecc_op_seq #(
  parameter int unsigned DWORD_W = 8
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 launch,
  input  wire logic                 with_rmodn,
  input  wire logic [DWORD_W-1:0]   dwords,
  output logic                      busy,
  output logic                      rmodn_done,
  output logic                      op_done,
  output ecc_cmd_pkg::seq_phase_e   phase
);

  typedef enum {
    st_idle,
    st_rmodn,
    st_oper
  } seq_st_e;

  seq_st_e     st_ff;
  logic [15:0] cnt_ff;
  logic [15:0] op_len_ff;
  logic        rmodn_done_ff;
  logic        op_done_ff;

  if (DWORD_W < 1 || DWORD_W > 8) begin : g_bad_width
    $error("ecc_op_seq: DWORD_W must be 1..8");
  end

  // latency grows with operand length so a longer operand keeps busy longer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff         <= st_idle;
      cnt_ff        <= 16'h0000;
      op_len_ff     <= 16'h0000;
      rmodn_done_ff <= 1'b0;
      op_done_ff    <= 1'b0;
    end else begin
      rmodn_done_ff <= 1'b0;
      op_done_ff    <= 1'b0;
      case (st_ff)
        st_idle: begin
          if (launch) begin
            op_len_ff <= 16'(`ECC_OP_BASE_CYCLES + 16'(dwords) * `ECC_CYCLES_PER_DWORD);
            if (with_rmodn) begin
              st_ff  <= st_rmodn;
              cnt_ff <= `ECC_RMODN_CYCLES - 16'h0001;
            end else begin
              st_ff  <= st_oper;
              cnt_ff <= 16'(`ECC_OP_BASE_CYCLES + 16'(dwords) * `ECC_CYCLES_PER_DWORD
                            - 16'h0001);
            end
          end
        end
        st_rmodn: begin
          if (cnt_ff == 16'h0000) begin
            rmodn_done_ff <= 1'b1;
            st_ff         <= st_oper;
            cnt_ff        <= op_len_ff - 16'h0001;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        st_oper: begin
          if (cnt_ff == 16'h0000) begin
            op_done_ff <= 1'b1;
            st_ff      <= st_idle;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        default: begin
          st_ff <= st_idle;
        end
      endcase
    end
  end

  assign busy       = (st_ff != st_idle);
  assign rmodn_done = rmodn_done_ff;
  assign op_done    = op_done_ff;

  always_comb begin
    case (st_ff)
      st_rmodn: phase = ecc_cmd_pkg::phase_rmodn;
      st_oper:  phase = ecc_cmd_pkg::phase_oper;
      default:  phase = ecc_cmd_pkg::phase_idle;
    endcase
  end

endmodule : ecc_op_seq
`default_nettype wire

/* logic/ecc_cmd_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecc_cmd_params.svh"

module ecc_cmd_regs #(
  parameter int unsigned max_operand_size_param = 3
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output ecc_cmd_pkg::exec_s      exec,
  output ecc_cmd_pkg::seq_phase_e phase,
  output logic                    engine_busy,
  output logic                    op_done
);

  localparam logic [7:0] max_dwords = 8'(1 << max_operand_size_param);

  if (max_operand_size_param > 7) begin : g_bad_size
    $error("ecc_cmd_regs: max_operand_size_param must be 0..7");
  end

  ecc_cmd_pkg::command_s cmd_ff;
  ecc_cmd_pkg::exec_s    exec_ff;
  logic                  start_ff;
  logic                  refused_ff;
  logic                  rmodn_latched_ff;
  logic [31:0]           prdata_ff;

  logic                  acc;
  logic                  wr;
  logic                  rd;
  logic                  hit_cmd;
  logic                  hit_ctl;
  logic                  hit_sts;
  logic                  hit_lch;
  logic                  mapped;
  logic                  start_req;
  logic                  start_live;
  logic                  cmd_valid;
  logic                  launch;
  logic                  seq_busy;
  logic                  seq_rmodn_done;
  logic                  seq_op_done;
  ecc_cmd_pkg::prim_op_e dec_op;
  logic [15:0]           dec_key_bits;
  logic [15:0]           dec_curve_bits;

  // apb decode, zero wait states
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign rd      = acc && !pwrite;
  assign hit_cmd = (paddr == `ECC_CMD_ADDR_COMMAND);
  assign hit_ctl = (paddr == `ECC_CMD_ADDR_CONTROL);
  assign hit_sts = (paddr == `ECC_CMD_ADDR_STATUS);
  assign hit_lch = (paddr == `ECC_CMD_ADDR_LAUNCH);
  assign mapped  = hit_cmd || hit_ctl || hit_sts || hit_lch;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata  = prdata_ff;

  // primitive op decode; anything outside group 0 decodes to prim_none and its start is refused
  always_comb begin
    dec_op = ecc_cmd_pkg::prim_none;
    if (cmd_ff.operation_code[`ECC_CMD_OPGROUP_MSB:`ECC_CMD_OPGROUP_LSB]
        == `ECC_GROUP_PRIMITIVE) begin
      case (cmd_ff.operation_code[`ECC_CMD_OPLOW_MSB:`ECC_CMD_OPLOW_LSB])
        `ECC_OP_MOD_ADD:      dec_op = ecc_cmd_pkg::prim_mod_add;
        `ECC_OP_MOD_SUB:      dec_op = ecc_cmd_pkg::prim_mod_sub;
        `ECC_OP_MOD_MUL:      dec_op = ecc_cmd_pkg::prim_mod_mul;
        `ECC_OP_MOD_RED:      dec_op = ecc_cmd_pkg::prim_mod_red;
        `ECC_OP_MOD_DIV:      dec_op = ecc_cmd_pkg::prim_mod_div;
        `ECC_OP_MOD_INV_ODD:  dec_op = ecc_cmd_pkg::prim_mod_inv_odd;
        `ECC_OP_MUL:          dec_op = ecc_cmd_pkg::prim_mul;
        `ECC_OP_MOD_INV_EVEN: dec_op = ecc_cmd_pkg::prim_mod_inv_even;
        default:              dec_op = ecc_cmd_pkg::prim_none;
      endcase
    end
  end

  // width of the operand as data or key
  always_comb begin
    case (cmd_ff.operand_dword_count)
      `ECC_SIZE_KEY_128: dec_key_bits = `ECC_BITS_128;
      `ECC_SIZE_KEY_256: dec_key_bits = `ECC_BITS_256;
      default:           dec_key_bits = 16'(cmd_ff.operand_dword_count) << `ECC_DWORD_BITS;
    endcase
  end

  // width of the operand as a curve, same table for either field
  always_comb begin
    case (cmd_ff.operand_dword_count)
      `ECC_SIZE_CURVE_192: dec_curve_bits = `ECC_BITS_192;
      `ECC_SIZE_CURVE_256: dec_curve_bits = `ECC_BITS_256;
      default:             dec_curve_bits = 16'(cmd_ff.operand_dword_count) << `ECC_DWORD_BITS;
    endcase
  end

  // size of zero or above the operand space cannot be served
  assign cmd_valid = (dec_op != ecc_cmd_pkg::prim_none)
                     && (cmd_ff.operand_dword_count != 8'h00)
                     && (cmd_ff.operand_dword_count <= max_dwords);
  assign start_req = wr && hit_ctl && pwdata[`ECC_CTL_START_BIT];
  assign start_live = start_ff && seq_busy; // flop lags busy by one cycle at the end
  assign launch    = start_req && !start_live && cmd_valid;

  // command register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff <= ecc_cmd_pkg::command_s'(`ECC_CMD_RESET);
    end else begin
      if (wr && hit_cmd) begin
        cmd_ff.param_b_negative    <= pwdata[`ECC_CMD_SIGN_B_BIT];
        cmd_ff.param_a_negative    <= pwdata[`ECC_CMD_SIGN_A_BIT];
        cmd_ff.operand_dword_count <= pwdata[`ECC_CMD_DWORDS_MSB:`ECC_CMD_DWORDS_LSB];
        cmd_ff.field_binary        <= pwdata[`ECC_CMD_FIELD_BIT];
        cmd_ff.operation_code      <= pwdata[`ECC_CMD_OPGROUP_MSB:`ECC_CMD_OPLOW_LSB];
      end
      // a fresh write of 1 wins over the self clear
      if (wr && hit_cmd && pwdata[`ECC_CMD_RECOMPUTE_BIT]) begin
        cmd_ff.recompute_r_mod_n <= 1'b1;
      end else if (seq_rmodn_done && rmodn_latched_ff) begin
        cmd_ff.recompute_r_mod_n <= 1'b0;
      end
    end
  end

  // recompute request as captured at launch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rmodn_latched_ff <= 1'b0;
    end else if (launch) begin
      rmodn_latched_ff <= cmd_ff.recompute_r_mod_n;
    end else if (seq_rmodn_done) begin
      rmodn_latched_ff <= 1'b0;
    end
  end

  // start bit: high for the whole operation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_ff <= 1'b0;
    end else if (launch) begin
      start_ff <= 1'b1;
    end else if (seq_op_done) begin
      start_ff <= 1'b0;
    end
  end

  // refused start: sticky, cleared by writing 1, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_ff <= 1'b0;
    end else if (start_req && !start_live && !cmd_valid) begin
      refused_ff <= 1'b1;
    end else if (wr && hit_lch && pwdata[`ECC_LCH_REFUSED_BIT]) begin
      refused_ff <= 1'b0;
    end
  end

  // snapshot so later command writes do not disturb a running op
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exec_ff <= '0;
    end else if (launch) begin
      exec_ff.op                  <= dec_op;
      exec_ff.field_binary        <= cmd_ff.field_binary;
      exec_ff.param_a_negative    <= cmd_ff.param_a_negative;
      exec_ff.param_b_negative    <= cmd_ff.param_b_negative;
      exec_ff.operand_dword_count <= cmd_ff.operand_dword_count;
      exec_ff.key_width_bits      <= dec_key_bits;
      exec_ff.curve_width_bits    <= dec_curve_bits;
    end
  end

  // read data registered when the setup phase is sampled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= 32'h0000_0000;
      case (1'b1)
        (paddr == `ECC_CMD_ADDR_COMMAND): begin
          prdata_ff[`ECC_CMD_RECOMPUTE_BIT]                   <= cmd_ff.recompute_r_mod_n;
          prdata_ff[`ECC_CMD_SIGN_B_BIT]                      <= cmd_ff.param_b_negative;
          prdata_ff[`ECC_CMD_SIGN_A_BIT]                      <= cmd_ff.param_a_negative;
          prdata_ff[`ECC_CMD_DWORDS_MSB:`ECC_CMD_DWORDS_LSB]  <= cmd_ff.operand_dword_count;
          prdata_ff[`ECC_CMD_FIELD_BIT]                       <= cmd_ff.field_binary;
          prdata_ff[`ECC_CMD_OPGROUP_MSB:`ECC_CMD_OPLOW_LSB]  <= cmd_ff.operation_code;
          prdata_ff[`ECC_CMD_RSVD_MSB:`ECC_CMD_RSVD_LSB]      <= 13'h0000;
        end
        (paddr == `ECC_CMD_ADDR_CONTROL): begin
          prdata_ff[`ECC_CTL_START_BIT] <= start_live;
        end
        (paddr == `ECC_CMD_ADDR_STATUS): begin
          prdata_ff[`ECC_STS_BUSY_BIT] <= seq_busy;
        end
        (paddr == `ECC_CMD_ADDR_LAUNCH): begin
          prdata_ff[`ECC_LCH_REFUSED_BIT] <= refused_ff;
          prdata_ff[`ECC_LCH_PENDING_BIT] <= cmd_ff.recompute_r_mod_n;
        end
        default: begin
          prdata_ff <= 32'h0000_0000;
        end
      endcase
    end
  end

  ecc_op_seq #(
    .DWORD_W (8)
  ) u_seq (
    .clk        (clk),
    .rst_n      (rst_n),
    .launch     (launch),
    .with_rmodn (cmd_ff.recompute_r_mod_n),
    .dwords     (cmd_ff.operand_dword_count),
    .busy       (seq_busy),
    .rmodn_done (seq_rmodn_done),
    .op_done    (seq_op_done),
    .phase      (phase)
  );

  assign exec        = exec_ff;
  assign engine_busy = seq_busy;
  assign op_done     = seq_op_done;

endmodule : ecc_cmd_regs
`default_nettype wire

/* sim/ecc_cmd_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecc_cmd_params.svh"

module ecc_cmd_regs_properties #(
  parameter int unsigned max_operand_size_param = 3
) (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire ecc_cmd_pkg::exec_s      exec,
  input wire ecc_cmd_pkg::seq_phase_e phase,
  input wire logic                    engine_busy,
  input wire logic                    op_done
);
  logic [31:0]             cmd_ff;
  logic [15:0]             cnt_ff;
  ecc_cmd_pkg::seq_phase_e prev_ff;
  logic                    acc;
  logic                    go;
  logic                    ok;
  logic [3:0]              low;
  logic [7:0]              dw;
  assign acc = psel && penable;
  assign go  = acc && pwrite && paddr == `ECC_CMD_ADDR_CONTROL && pwdata[0];
  assign low = cmd_ff[3:0];
  assign dw  = cmd_ff[15:8];
  assign ok  = cmd_ff[6:4] == 3'h0 && low != 4'h0 && low != 4'h7 && low < 4'ha && dw != 8'h00
               && dw <= 8'(1 << max_operand_size_param);
  // shadow of the command fields; flag 31 is not used, so its self-clear does not matter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cmd_ff <= 32'h0000_0000;
    else if (acc && pwrite && paddr == `ECC_CMD_ADDR_COMMAND) cmd_ff <= pwdata & 32'he000_ffff;
  end
  // cycles spent in the phase just left
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= 16'h0000;
      prev_ff <= ecc_cmd_pkg::phase_idle;
    end else begin
      cnt_ff  <= (phase != prev_ff) ? 16'h0001 : cnt_ff + 16'h0001;
      prev_ff <= phase;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_EXEC_FIELDS: assert property ($rose(engine_busy) |->
    exec.param_b_negative == cmd_ff[30] && exec.param_a_negative == cmd_ff[29]
    && exec.field_binary == cmd_ff[7] && exec.operand_dword_count == dw)
    else $error("command fields not captured at launch");
  AST_OP_MAP: assert property ($rose(engine_busy) |->
    exec.op == ecc_cmd_pkg::prim_op_e'(low <= 4'h6 ? low : low - 4'h1))
    else $error("wrong primitive decoded");
  AST_WIDTHS: assert property ($rose(engine_busy) |->
    exec.key_width_bits == (dw == 8'h02 ? `ECC_BITS_128 : dw == 8'h03 ? `ECC_BITS_256
      : {2'h0, dw, 6'h00}) && exec.curve_width_bits == (dw == 8'h03 ? `ECC_BITS_192
      : dw == 8'h04 ? `ECC_BITS_256 : {2'h0, dw, 6'h00}))
    else $error("size code decoded wrongly");
  AST_LAUNCH: assert property (go && ok && !engine_busy |=> engine_busy)
    else $error("valid start not launched");
  AST_REFUSE: assert property (go && !ok && !engine_busy |=> !engine_busy)
    else $error("invalid command launched");
  AST_IGNORE: assert property (go && engine_busy |=> $stable(exec))
    else $error("start taken while busy");
  AST_BUSY_PHASE: assert property (engine_busy == (phase != ecc_cmd_pkg::phase_idle))
    else $error("busy disagrees with phase");
  AST_RMODN: assert property (prev_ff == ecc_cmd_pkg::phase_rmodn && phase != prev_ff |->
    cnt_ff == 16'h0040 && phase == ecc_cmd_pkg::phase_oper)
    else $error("recompute phase length wrong");
  AST_OP_LEN: assert property (prev_ff == ecc_cmd_pkg::phase_oper && phase != prev_ff |->
    cnt_ff == {5'h00, exec.operand_dword_count, 3'h0} + 16'h0004 && op_done)
    else $error("operation length wrong");
  AST_DONE: assert property (op_done |-> !engine_busy && $past(engine_busy))
    else $error("done without busy falling");
  AST_UNMAPPED: assert property (acc |-> pready && pslverr == !(paddr inside
    {`ECC_CMD_ADDR_COMMAND, `ECC_CMD_ADDR_CONTROL, `ECC_CMD_ADDR_STATUS, `ECC_CMD_ADDR_LAUNCH}))
    else $error("error response wrong");
  AST_RSVD_ZERO: assert property (acc && !pwrite && paddr == `ECC_CMD_ADDR_COMMAND |->
    prdata[28:16] == 13'h0000)
    else $error("reserved command bits not zero");
  COV_RMODN: cover property (phase == ecc_cmd_pkg::phase_rmodn);
  COV_DONE: cover property (op_done);
  COV_ERR: cover property (acc && pslverr);
endmodule : ecc_cmd_regs_properties

bind ecc_cmd_regs ecc_cmd_regs_properties #(
  .max_operand_size_param(max_operand_size_param)
) props_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .exec(exec), .phase(phase), .engine_busy(engine_busy), .op_done(op_done));
`default_nettype wire

/* sim/ecc_cmd_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecc_cmd_params.svh"

module ecc_cmd_regs_tb_top;
  localparam int unsigned P = 2;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [31:0]             paddr = 32'h0000_0000;
  logic [31:0]             pwdata = 32'h0000_0000;
  logic [31:0]             seed_ff = 32'h0000_f94f;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    engine_busy;
  logic                    op_done;
  ecc_cmd_pkg::exec_s      exec;
  ecc_cmd_pkg::seq_phase_e phase;
  int                      fails = 0;
  int                      checks = 0;
  int                      cyc = 0;
  logic [31:0]             rd_q[$];
  ecc_cmd_pkg::prim_op_e   op_q[$];
  logic [7:0]              sizes[3] = '{8'h00, 8'h04, 8'h05};

  always #20 clk = ~clk;

  ecc_cmd_regs #(.max_operand_size_param(P)) ecc_cmd_regs_i (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .exec(exec), .phase(phase),
    .engine_busy(engine_busy), .op_done(op_done));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // hold the whole request until pready is seen at an edge
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [31:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task wait_idle;
    @(negedge clk);
    while (engine_busy !== 1'b0) @(negedge clk);
  endtask : wait_idle

  task run_op(input logic [3:0] low, input logic [7:0] dw, input logic rc);
    logic [31:0] c;
    seed_ff = xs(seed_ff);
    c = {rc, seed_ff[1:0], 13'h0000, dw, seed_ff[2], 3'h0, low};
    apb(1'b1, `ECC_CMD_ADDR_COMMAND, c);
    apb(1'b1, `ECC_CMD_ADDR_CONTROL, 32'h0000_0001);
    if (low != 4'h0 && low != 4'h7 && low < 4'ha && dw != 8'h00 && dw <= 8'(1 << P)) begin
      op_q.push_back(ecc_cmd_pkg::prim_op_e'(low <= 4'h6 ? low : low - 4'h1));
      rd(`ECC_CMD_ADDR_STATUS, 32'h0001_0000);
      apb(1'b1, `ECC_CMD_ADDR_CONTROL, 32'h0000_0001);
    end else begin
      rd(`ECC_CMD_ADDR_LAUNCH, 32'h0000_0001);
      apb(1'b1, `ECC_CMD_ADDR_LAUNCH, 32'h0000_0001);
      rd(`ECC_CMD_ADDR_LAUNCH, 32'h0000_0000);
    end
    wait_idle();
    rd(`ECC_CMD_ADDR_CONTROL, 32'h0000_0000);
    rd(`ECC_CMD_ADDR_COMMAND, c & 32'h7fff_ffff);
  endtask : run_op

  // second process: one note per read, one per launched operation
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) check(prdata, rd_q.pop_front());
    if (op_done === 1'b1) begin
      if (op_q.size() == 0) check(32'h0000_0001, 32'h0000_0000);
      else check({28'h0, exec.op}, {28'h0, op_q.pop_front()});
    end
    cyc++;
    if (cyc > 20000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ECC_CMD_ADDR_COMMAND, 32'h0000_0000);
    rd(`ECC_CMD_ADDR_CONTROL, 32'h0000_0000);
    rd(`ECC_CMD_ADDR_STATUS, 32'h0000_0000);
    rd(`ECC_CMD_ADDR_LAUNCH, 32'h0000_0000);
    rd(32'h5000_6000, 32'h0000_0000);
    $display("test reset done");
    apb(1'b1, `ECC_CMD_ADDR_COMMAND, 32'hffff_ffff);
    rd(`ECC_CMD_ADDR_COMMAND, 32'he000_ffff);
    run_op(4'h1, 8'h01, 1'b1);
    $display("test reserved done");
    for (int i = 0; i < 10; i++) run_op(4'(i), 8'(1 + i % 4), 1'b0);
    $display("test codes done");
    foreach (sizes[i]) run_op(4'h1, sizes[i], 1'b0);
    $display("test sizes done");
    run_op(4'h3, 8'h02, 1'b1);
    run_op(4'h8, 8'h01, 1'b0);
    $display("test recompute done");
    complete_run();
  end
endmodule : ecc_cmd_regs_tb_top
`default_nettype wire
